// ### rtl/lws_pkg.sv
// shared constants and types for the list waveform trigger sequencer
package lws_pkg;
   // timing
   localparam int CLK_NS = 25;
   localparam int TICK_NS = 1000; // timers count in microseconds
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLT_TIME_NS = 400000; // trigger level must hold 0.4 ms
   localparam int FLT_CYC = (FLT_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] WAIT_MIN_US = 16'h00fa; // 250 us
   localparam logic [15:0] WAIT_MAX_US = 16'h84d0; // 34000 us
   // list capacity choices and storage
   localparam int MEM_DEPTH = 5900;
   localparam logic [12:0] CAP_A = 13'h0b86; // 2950
   localparam logic [12:0] CAP_B = 13'h0f5d; // 3933
   localparam logic [12:0] CAP_C = 13'h170c; // 5900
   localparam logic [4:0] QRD_MAX = 5'h10; // values per read window
   // sweep angles in hundredths of a degree
   localparam logic [15:0] SWP_MIN = 16'h0001;
   localparam logic [15:0] SWP_STOP_DEF = 16'h8ca0; // 360.00
   // reset values
   localparam logic [1:0] CAP_RST = 2'h2;
   localparam logic TPOL_RST = 1'b1;
   // error codes, two's complement
   localparam logic [15:0] ERR_CONFLICT = 16'hff23; // -221
   localparam logic [15:0] ERR_MISMATCH = 16'hff1e; // -226
   localparam logic [15:0] ERR_FULL = 16'hff21; // -223
   localparam logic [15:0] ERR_CMD = 16'hff9c; // -100
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TRIG = 8'h04;
   localparam logic [7:0] OFF_WAIT = 8'h08;
   localparam logic [7:0] OFF_CAP = 8'h0c;
   localparam logic [7:0] OFF_VAPP = 8'h10;
   localparam logic [7:0] OFF_DAPP = 8'h14;
   localparam logic [7:0] OFF_CAPP = 8'h18;
   localparam logic [7:0] OFF_PNTS = 8'h1c;
   localparam logic [7:0] OFF_QSTR = 8'h20;
   localparam logic [7:0] OFF_QDAT = 8'h24;
   localparam logic [7:0] OFF_WAVE = 8'h28;
   localparam logic [7:0] OFF_WAMP = 8'h2c;
   localparam logic [7:0] OFF_WOFS = 8'h30;
   localparam logic [7:0] OFF_WLIM = 8'h34;
   localparam logic [7:0] OFF_WDUR = 8'h38;
   localparam logic [7:0] OFF_SWP = 8'h3c;
   localparam logic [7:0] OFF_ERR = 8'h40;
   localparam logic [7:0] OFF_OUT = 8'h44;
   // types
   typedef enum logic [2:0] {ST_IDLE, ST_GEN, ST_EXEC, ST_DWELL, ST_PULSE, ST_WAIT} lws_state_t;
   typedef enum logic [1:0] {STEP_NORM, STEP_TRIG, STEP_WHIGH, STEP_WLEDG} lws_step_t;
   typedef enum logic [2:0] {W_SQUARE, W_RAMPUP, W_RAMPDN, W_TRI, W_SINE, W_LEVEL} lws_wave_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } lws_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lws_apb_rsp_t;
   typedef struct packed {
      lws_state_t st;
      lws_step_t typ;
      lws_wave_t gtype;
      logic [12:0] vptr;
      logic [12:0] dptr;
      logic [12:0] cptr;
      logic [12:0] qptr;
      logic [12:0] idx;
      logic [4:0] qcnt;
      logic [3:0] gk;
      logic [15:0] outv;
      logic [15:0] tmr;
      logic [15:0] tdur;
      logic [15:0] wto;
      logic [15:0] wamp;
      logic [15:0] wofs;
      logic [15:0] wlim;
      logic [15:0] wdur;
      logic [15:0] sstart;
      logic [15:0] sstop;
      logic [15:0] err;
      logic tpol;
      logic flag;
      logic [1:0] cap;
      logic [5:0] pre;
      logic [1:0] sync;
      logic [15:0] fcnt;
      logic flt;
      logic fltp;
      logic [31:0] prdata;
   } lws_regs_t;
endpackage

// ### rtl/lws_sequencer.sv
// list sequencer: apb registers, point list, waveform generator, trigger steps
`timescale 1ns/1ps
// Function
// [RULE_01] trigger point pulses flag for set duration
// [RULE_02] trigger point without duration gives -221
// [RULE_03] step point needs prior list entries
// [RULE_04] dwell count mismatch gives -226
// [RULE_05] points stored consecutively up to capacity
// [RULE_06] clear resets write location to zero
// [RULE_07] voltage access refused while current entries
// [RULE_08] host keeps lines within input buffer
// [RULE_09] read window returns up to 16 values
// [RULE_10] generator appends voltage and dwell points
// [RULE_11] generated points offset and clamped to limits
// [RULE_12] sweep stores start and stop angles
// [RULE_13] pointer counts points, next free location
// [RULE_14] wait step sets output at once
// [RULE_15] wait-high skipped if high with timeout
// [RULE_16] wait-high ends on high or timeout
// [RULE_17] trigger level valid after 0.4 ms
// [RULE_18] falling wait ignores already low input
// [RULE_19] falling wait ends on fall or timeout
// [RULE_20] timeout 250 us to 34 ms, zero infinite
// [RULE_21] list edits refused while executing
// [RULE_22] trigger input synchronised before filter
// [RULE_23] instrument holds levels beyond filter time
module lws_sequencer #(
   parameter int FLT_CYCLES = lws_pkg::FLT_CYC
)
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // apb slave
   input wire lws_pkg::lws_apb_req_t APB_REQ,
   output lws_pkg::lws_apb_rsp_t APB_RSP,
   // trigger port and flag transistor
   input wire logic TRIG_IN,
   output logic FLAG_TRANSISTOR_ON,
   // sequencer status
   output logic [15:0] OUT_VALUE,
   output logic RUNNING
);
   import lws_pkg::*;

   localparam lws_regs_t REGS_RST = '{st: ST_IDLE, typ: STEP_NORM, gtype: W_SQUARE,
      tpol: TPOL_RST, cap: CAP_RST, sstart: SWP_MIN, sstop: SWP_STOP_DEF, default: '0};

   lws_regs_t s;
   lws_regs_t n;
   logic [17:0] vmem [MEM_DEPTH];
   logic [15:0] dmem [MEM_DEPTH];
   logic [17:0] rv;
   logic [15:0] rd;
   logic [17:0] qv;
   logic vm_we;
   logic dm_we;
   logic [12:0] vm_wa;
   logic [12:0] dm_wa;
   logic [17:0] vm_wd;
   logic [15:0] dm_wd;
   logic [12:0] cap_lim;
   logic [12:0] qaddr;
   logic [12:0] qaddr_n;
   logic [12:0] cmp;
   logic [31:0] rdat;
   logic hit;
   logic busy;
   logic wr;
   logic va;
   logic tick;
   logic fall;
   logic adv;
   lws_step_t typ_w;
   lws_step_t rtyp;
   logic [15:0] wv;
   logic [5:0] m;
   logic signed [15:0] half;
   logic signed [21:0] prod;
   logic signed [22:0] gv;
   logic signed [22:0] glim;
   logic [15:0] gdwell;

   // quarter-wave symmetric sine, peak 16
   function automatic logic [5:0] sine_m(input logic [3:0] k);
      logic [5:0] v;
      case (k[2:0])
         3'h0: v = 6'h00;
         3'h1: v = 6'h06;
         3'h2: v = 6'h0b;
         3'h3: v = 6'h0f;
         3'h4: v = 6'h10;
         3'h5: v = 6'h0f;
         3'h6: v = 6'h0b;
         default: v = 6'h06;
      endcase
      return k[3] ? 6'h00 - v : v;
   endfunction

   assign busy = (s.st != ST_IDLE);
   assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
   assign va = wr && (APB_REQ.paddr == OFF_VAPP) && !busy;
   assign typ_w = lws_step_t'(APB_REQ.pwdata[17:16]);
   assign rtyp = lws_step_t'(rv[17:16]);
   assign qaddr = s.qptr + 13'(s.qcnt);
   assign qaddr_n = n.qptr + 13'(n.qcnt);
   assign cmp = (s.cptr != 13'h0) ? s.cptr : s.vptr;
   assign tick = (s.pre == 6'(TICK_CYC - 1));
   assign fall = s.fltp & ~s.flt;
   assign APB_RSP.prdata = s.prdata;
   assign APB_RSP.pready = 1'b1;
   assign APB_RSP.pslverr = APB_REQ.psel & APB_REQ.penable & ~hit;
   assign FLAG_TRANSISTOR_ON = s.flag;
   assign OUT_VALUE = s.outv;
   assign RUNNING = busy;

   // capacity select
   always_comb
   begin
      case (s.cap)
         2'h0: cap_lim = CAP_A;
         2'h1: cap_lim = CAP_B;
         default: cap_lim = CAP_C;
      endcase
   end

   // waveform sample: shape times half amplitude plus offset, or the amplitude alone for level, clamped
   always_comb
   begin
      unique case (s.gtype)
         W_SQUARE: m = s.gk[3] ? 6'h30 : 6'h10;
         W_RAMPUP: m = {1'b0, s.gk, 1'b0} - 6'h0f;
         W_RAMPDN: m = 6'h0f - {1'b0, s.gk, 1'b0};
         W_TRI: m = s.gk[3] ? 6'h30 - {s.gk, 2'b00} : {s.gk, 2'b00} - 6'h10;
         W_SINE: m = sine_m(s.gk);
         W_LEVEL: m = 6'h00;
         default: m = 6'h00; // codes 6 and 7 give a flat line at the offset
      endcase
      half = signed'(s.wamp) >>> 1;
      prod = 22'(half * signed'(m));
      glim = signed'({7'h00, s.wlim});
      if (s.gtype == W_LEVEL)
         gv = 23'(signed'(s.wamp));
      else
         gv = 23'(prod >>> 4) + 23'(signed'(s.wofs)); // [RULE_11]
      if (gv > glim)
         gv = glim; // [RULE_11]
      else if (gv < -glim)
         gv = -glim;
      gdwell = (s.gtype == W_LEVEL) ? s.wdur : {4'h0, s.wdur[15:4]};
   end

   // read mux, prepared in the setup phase so pready can stay high
   always_comb
   begin
      hit = 1'b1;
      rdat = 32'h0;
      case (APB_REQ.paddr)
         OFF_CTRL: rdat = {30'h0, s.flag, busy};
         OFF_TRIG: rdat = {15'h0, s.tpol, s.tdur};
         OFF_WAIT: rdat = {16'h0, s.wto};
         OFF_CAP: rdat = {30'h0, s.cap};
         OFF_VAPP, OFF_DAPP, OFF_CAPP, OFF_QSTR, OFF_WAVE: rdat = 32'h0;
         OFF_PNTS: rdat = {19'h0, s.vptr}; // [RULE_13]
         OFF_QDAT:
         begin
            if (s.qcnt < QRD_MAX && qaddr < s.vptr) // [RULE_09]
               rdat = {{16{qv[15]}}, qv[15:0]};
         end
         OFF_WAMP: rdat = {16'h0, s.wamp};
         OFF_WOFS: rdat = {16'h0, s.wofs};
         OFF_WLIM: rdat = {16'h0, s.wlim};
         OFF_WDUR: rdat = {16'h0, s.wdur};
         OFF_SWP: rdat = {s.sstop, s.sstart};
         OFF_ERR: rdat = {{16{s.err[15]}}, s.err};
         OFF_OUT: rdat = {{16{s.outv[15]}}, s.outv};
         default: hit = 1'b0;
      endcase
   end

   // next state: filter, timers, sequencer, then bus writes which may override
   always_comb
   begin
      n = s;
      adv = 1'b0;
      vm_we = 1'b0;
      dm_we = 1'b0;
      vm_wa = s.vptr;
      dm_wa = s.dptr;
      vm_wd = {STEP_NORM, gv[15:0]};
      dm_wd = gdwell;
      wv = APB_REQ.pwdata[15:0];
      n.sync = {s.sync[0], TRIG_IN}; // [RULE_22]
      n.fltp = s.flt;
      // level must hold a full filter time before it is believed
      if (s.sync[1] == s.flt)
         n.fcnt = 16'h0;
      else if (s.fcnt == 16'(FLT_CYCLES - 1))
      begin
         n.flt = s.sync[1]; // [RULE_17]
         n.fcnt = 16'h0;
      end
      else
         n.fcnt = s.fcnt + 16'h1;
      n.pre = tick ? 6'h00 : s.pre + 6'h01;
      if (tick && s.tmr != 16'h0)
         n.tmr = s.tmr - 16'h1;
      unique case (s.st)
         ST_IDLE: ;
         ST_GEN:
         begin
            if (s.vptr >= cap_lim || s.dptr >= cap_lim)
               n.st = ST_IDLE;
            else
            begin
               vm_we = 1'b1; // [RULE_10]
               dm_we = 1'b1;
               n.vptr = s.vptr + 13'h1;
               n.dptr = s.dptr + 13'h1;
               n.gk = s.gk + 4'h1;
               if (s.gtype == W_LEVEL || s.gk == 4'hf)
                  n.st = ST_IDLE;
            end
         end
         ST_EXEC:
         begin
            n.outv = rv[15:0]; // [RULE_14]
            n.typ = rtyp;
            unique case (rtyp)
               STEP_NORM:
               begin
                  n.tmr = rd;
                  n.st = ST_DWELL;
               end
               STEP_TRIG:
               begin
                  n.flag = s.tpol; // [RULE_01]
                  n.tmr = s.tdur;
                  n.st = ST_PULSE;
               end
               STEP_WHIGH:
               begin
                  if (s.wto != 16'h0 && s.flt)
                     adv = 1'b1; // [RULE_15]
                  else
                  begin
                     n.tmr = s.wto;
                     n.st = ST_WAIT;
                  end
               end
               STEP_WLEDG:
               begin
                  n.tmr = s.wto; // [RULE_18]
                  n.st = ST_WAIT;
               end
            endcase
         end
         ST_DWELL: adv = (s.tmr == 16'h0);
         ST_PULSE:
         begin
            if (s.tmr == 16'h0)
            begin
               n.flag = ~s.tpol; // [RULE_01]
               adv = 1'b1;
            end
         end
         ST_WAIT:
         begin
            // zero timeout waits forever; a fall needs a high first
            if (s.typ == STEP_WHIGH ? s.flt : fall) // [RULE_16] [RULE_19]
               adv = 1'b1;
            else if (s.wto != 16'h0 && s.tmr == 16'h0)
               adv = 1'b1; // [RULE_16] [RULE_19]
         end
      endcase
      if (adv)
      begin
         if (s.idx + 13'h1 >= s.vptr)
            n.st = ST_IDLE;
         else
         begin
            n.idx = s.idx + 13'h1;
            n.st = ST_EXEC;
         end
      end
      if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite)
         n.prdata = rdat;
      // read side effects; error clear first so a new error wins
      if (APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite)
      begin
         if (APB_REQ.paddr == OFF_ERR)
            n.err = 16'h0;
         if ((APB_REQ.paddr == OFF_PNTS || APB_REQ.paddr == OFF_QDAT) && s.cptr != 13'h0)
            n.err = ERR_CONFLICT; // [RULE_07]
         if (APB_REQ.paddr == OFF_QDAT && s.qcnt < QRD_MAX)
            n.qcnt = s.qcnt + 5'h01; // [RULE_09]
      end
      if (wr)
      begin
         case (APB_REQ.paddr)
            OFF_CTRL:
            begin
               if (APB_REQ.pwdata[2])
               begin
                  n.st = ST_IDLE;
                  n.flag = ~s.tpol;
               end
               else if (APB_REQ.pwdata[0] && busy)
                  n.err = ERR_CMD; // [RULE_21]
               else if (APB_REQ.pwdata[0])
               begin
                  n.vptr = 13'h0; // [RULE_06]
                  n.dptr = 13'h0;
                  n.cptr = 13'h0;
                  n.qptr = 13'h0;
                  n.qcnt = 5'h00;
               end
               else if (APB_REQ.pwdata[1] && !busy)
               begin
                  if (s.dptr != cmp)
                     n.err = ERR_MISMATCH; // [RULE_04]
                  else if (s.vptr != 13'h0)
                  begin
                     n.idx = 13'h0;
                     n.st = ST_EXEC;
                  end
               end
            end
            OFF_TRIG:
            begin
               n.tdur = wv;
               n.tpol = APB_REQ.pwdata[16];
               if (!busy)
                  n.flag = ~APB_REQ.pwdata[16];
            end
            OFF_WAIT:
            begin
               if (wv != 16'h0 && wv < WAIT_MIN_US)
                  n.wto = WAIT_MIN_US; // [RULE_20]
               else if (wv > WAIT_MAX_US)
                  n.wto = WAIT_MAX_US;
               else
                  n.wto = wv;
            end
            OFF_CAP: n.cap = APB_REQ.pwdata[1:0]; // [RULE_05]
            OFF_WAMP: n.wamp = wv;
            OFF_WOFS: n.wofs = wv;
            OFF_WLIM: n.wlim = wv;
            OFF_WDUR: n.wdur = wv;
            OFF_SWP:
            begin
               n.sstart = (wv < SWP_MIN) ? SWP_MIN : wv; // [RULE_12]
               n.sstop = (APB_REQ.pwdata[31:16] == 16'h0) ? SWP_STOP_DEF
                  : APB_REQ.pwdata[31:16]; // [RULE_12]
            end
            OFF_VAPP, OFF_DAPP, OFF_CAPP, OFF_QSTR, OFF_WAVE:
            begin
               if (busy)
                  n.err = ERR_CMD; // [RULE_21]
               else if (APB_REQ.paddr == OFF_QSTR)
               begin
                  n.qptr = APB_REQ.pwdata[12:0];
                  n.qcnt = 5'h00;
               end
               else if (APB_REQ.paddr == OFF_CAPP)
               begin
                  if (s.cptr < cap_lim)
                     n.cptr = s.cptr + 13'h1;
               end
               else if (APB_REQ.paddr == OFF_DAPP)
               begin
                  if (s.dptr < cap_lim)
                  begin
                     dm_we = 1'b1;
                     dm_wd = wv;
                     n.dptr = s.dptr + 13'h1;
                  end
               end
               else if (s.cptr != 13'h0)
                  n.err = ERR_CONFLICT; // [RULE_07]
               else if (APB_REQ.paddr == OFF_WAVE)
               begin
                  n.gtype = lws_wave_t'(APB_REQ.pwdata[2:0]); // [RULE_10]
                  n.gk = 4'h0;
                  n.st = ST_GEN;
               end
               else if (typ_w != STEP_NORM && s.vptr == 13'h0)
                  n.err = ERR_CONFLICT; // [RULE_03]
               else if (typ_w == STEP_TRIG && s.tdur == 16'h0)
                  n.err = ERR_CONFLICT; // [RULE_02]
               else if (s.vptr >= cap_lim || (typ_w != STEP_NORM && s.dptr >= cap_lim))
                  n.err = ERR_FULL; // [RULE_05]
               else
               begin
                  vm_we = 1'b1; // [RULE_05]
                  vm_wd = {typ_w, wv};
                  n.vptr = s.vptr + 13'h1; // [RULE_13]
                  // steps carry an unused dwell so the lists stay balanced
                  if (typ_w != STEP_NORM)
                  begin
                     dm_we = 1'b1;
                     dm_wd = 16'h0;
                     n.dptr = s.dptr + 13'h1;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // list storage, written by bus or generator, read by sequencer and bus
   always_ff @(posedge SYS_CLK)
   begin
      if (vm_we)
         vmem[vm_wa] <= vm_wd;
      if (dm_we)
         dmem[dm_wa] <= dm_wd;
      rv <= (n.idx < 13'(MEM_DEPTH)) ? vmem[n.idx] : 18'h0;
      rd <= (n.idx < 13'(MEM_DEPTH)) ? dmem[n.idx] : 16'h0;
      qv <= (qaddr_n < 13'(MEM_DEPTH)) ? vmem[qaddr_n] : 18'h0;
   end

   // state register
   always_ff @(posedge SYS_CLK or negedge RESETN)
   begin
      if (!RESETN)
         s <= REGS_RST;
      else
         s <= n;
   end

   property p_flag_pulse;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_EXEC && rtyp == STEP_TRIG && !wr) |=> (s.flag == s.tpol && s.st == ST_PULSE);
   endproperty
   a_flag_pulse: assert property (p_flag_pulse) else $error("flag pulse not started"); // [RULE_01]

   property p_trig_nodur;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (va && s.cptr == 13'h0 && s.vptr != 13'h0 && typ_w == STEP_TRIG && s.tdur == 16'h0)
      |=> (s.err == ERR_CONFLICT && $stable(s.vptr));
   endproperty
   a_trig_nodur: assert property (p_trig_nodur) else $error("trigger without duration taken"); // [RULE_02]

   property p_step_empty;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (va && typ_w != STEP_NORM && s.vptr == 13'h0) |=> (s.vptr == 13'h0 && s.err == ERR_CONFLICT);
   endproperty
   a_step_empty: assert property (p_step_empty) else $error("step into empty list"); // [RULE_03]

   property p_len_mismatch;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr && APB_REQ.paddr == OFF_CTRL && APB_REQ.pwdata[2:0] == 3'h2 && !busy && s.dptr != cmp)
      |=> (s.st == ST_IDLE && s.err == ERR_MISMATCH);
   endproperty
   a_len_mismatch: assert property (p_len_mismatch) else $error("unbalanced list ran"); // [RULE_04]

   property p_clear;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr && APB_REQ.paddr == OFF_CTRL && APB_REQ.pwdata[2:0] == 3'h1 && !busy)
      |=> (s.vptr == 13'h0 && s.dptr == 13'h0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear left pointer"); // [RULE_06]

   property p_cur_block;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (va && s.cptr != 13'h0) |=> (s.err == ERR_CONFLICT && $stable(s.vptr));
   endproperty
   a_cur_block: assert property (p_cur_block) else $error("append with current list"); // [RULE_07]

   property p_ptr_inc;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (va && s.cptr == 13'h0 && typ_w == STEP_NORM && s.vptr < cap_lim)
      |=> (s.vptr == $past(s.vptr) + 13'h1);
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced"); // [RULE_13]

   property p_wait_out;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_EXEC) |=> (OUT_VALUE == $past(rv[15:0]));
   endproperty
   a_wait_out: assert property (p_wait_out) else $error("step value not applied"); // [RULE_14]

   property p_skip_high;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_EXEC && rtyp == STEP_WHIGH && s.wto != 16'h0 && s.flt && !wr)
      |=> (s.st != ST_WAIT);
   endproperty
   a_skip_high: assert property (p_skip_high) else $error("high wait not skipped"); // [RULE_15]

   property p_filter;
      @(posedge SYS_CLK) disable iff (!RESETN)
      $changed(s.flt) |-> ($past(s.fcnt) == 16'(FLT_CYCLES - 1));
   endproperty
   a_filter: assert property (p_filter) else $error("trigger level taken early"); // [RULE_17]

   property p_ledge_fall;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_WAIT && s.typ == STEP_WLEDG && fall && !wr) |=> (s.st != ST_WAIT);
   endproperty
   a_ledge_fall: assert property (p_ledge_fall) else $error("falling edge missed"); // [RULE_19]

   property p_busy_edit;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (wr && APB_REQ.paddr == OFF_VAPP && busy && s.st != ST_GEN)
      |=> (s.err == ERR_CMD && $stable(s.vptr));
   endproperty
   a_busy_edit: assert property (p_busy_edit) else $error("edit accepted while running"); // [RULE_21]

   property p_clamp;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (vm_we && s.st == ST_GEN) |-> (gv <= glim && gv >= -glim);
   endproperty
   a_clamp: assert property (p_clamp) else $error("generated point beyond limit"); // [RULE_11]
endmodule

// ### sim/lws_instr_model.sv
// trigger instrument model driving the trigger input pin
`timescale 1ns/1ps
module lws_instr_model (
   // clock
   input wire logic clk,
   // level asked for, flag seen
   input wire logic want_lvl,
   input wire logic flag_on,
   // trigger pin
   output logic trig
);
   // moves only on an edge; callers hold each level well past the filter
   // the instrument pulls its line low while the flag transistor conducts
   always_ff @(posedge clk)
   begin
      trig <= want_lvl & ~flag_on;
   end
endmodule

// ### sim/test_list_waveform_trigger_sequencer.sv
// self-checking bench for the list sequencer
`timescale 1ns/1ps
module test_list_waveform_trigger_sequencer;
   import lws_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic want = 1'b0;
   logic trig;
   logic flag;
   logic run;
   logic [15:0] outv;
   lws_apb_req_t req = '0;
   lws_apb_rsp_t rsp;
   logic [32:0] expq[$];
   logic [15:0] pts[18];
   int err_total = 0;
   int samples_checked = 0;
   lws_sequencer #(.FLT_CYCLES(8)) i_dut (.SYS_CLK(clk), .RESETN(rst_n), .APB_REQ(req),
      .APB_RSP(rsp), .TRIG_IN(trig), .FLAG_TRANSISTOR_ON(flag), .OUT_VALUE(outv),
      .RUNNING(run));
   lws_instr_model i_ins (.clk(clk), .want_lvl(want), .flag_on(flag), .trig(trig));
   // clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   task automatic wrap_up();
      $display("reads %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one transfer; a read notes its expected {pslverr, prdata}
   task automatic xf(input logic w, input logic [7:0] a, input logic [32:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d[31:0]};
      if (!w)
         expq.push_back(d);
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xf(1'b1, a, {1'b0, d});
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] d);
      xf(1'b0, a, d);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] e);
      samples_checked++;
      if (got !== e)
      begin
         err_total++;
         $display("CHECK FAILED %0t read %h expected %h", $time, got, e);
      end
   endtask
   task automatic chk_pin(input logic [15:0] got, input logic [15:0] e);
      samples_checked++;
      if (got !== e)
      begin
         err_total++;
         $display("CHECK FAILED %0t pins %h expected %h", $time, got, e);
      end
   endtask
   // watch completed reads; old values seen, so the edge order is safe
   // pins are checked too, only where reads fall in a steady stretch
   logic [32:0] exp_rd;
   always @(posedge clk)
   begin
      if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
      begin
         exp_rd = (expq.size() > 0) ? expq.pop_front() : 'x;
         chk({rsp.pslverr, rsp.prdata}, exp_rd);
         if (req.paddr == OFF_CTRL)
            chk_pin({14'h0, flag, run}, exp_rd[15:0]);
         if (req.paddr == OFF_OUT)
            chk_pin(outv, exp_rd[15:0]);
      end
   end
   // hang guard, well past the longest wait
   initial
   begin
      #1000000;
      err_total++;
      wrap_up();
   end
   initial
   begin
      pts[0] = 16'($urandom(54));
      wt(2);
      rst_n <= 1'b1;
      rd(OFF_TRIG, 33'h000010000);
      rd(OFF_WAIT, 33'h0);
      rd(OFF_SWP, 33'h08ca00001);
      rd(8'h80, 33'h100000000);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_VAPP, 32'h20005);
      rd(OFF_ERR, 33'h0ffffff23);
      for (int i = 0; i < 18; i++)
      begin
         pts[i] = 16'($urandom());
         wr(OFF_VAPP, {16'h0, pts[i]});
      end
      rd(OFF_PNTS, 33'h12);
      wr(OFF_QSTR, 32'h1);
      for (int i = 1; i < 17; i++)
         rd(OFF_QDAT, {1'b0, {16{pts[i][15]}}, pts[i]});
      rd(OFF_QDAT, 33'h0);
      wr(OFF_CTRL, 32'h1);
      rd(OFF_PNTS, 33'h0);
      wr(OFF_CAPP, 32'h0);
      wr(OFF_VAPP, 32'h1);
      rd(OFF_ERR, 33'h0ffffff23);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_VAPP, 32'h5);
      wr(OFF_VAPP, 32'h10003);
      rd(OFF_ERR, 33'h0ffffff23);
      wr(OFF_CTRL, 32'h2);
      rd(OFF_ERR, 33'h0ffffff1e);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_TRIG, 32'h10002);
      wr(OFF_VAPP, 32'h5);
      wr(OFF_DAPP, 32'h0);
      wr(OFF_VAPP, 32'h10003);
      wr(OFF_CTRL, 32'h2);
      wt(10);
      rd(OFF_CTRL, 33'h3);
      wt(150);
      rd(OFF_CTRL, 33'h0);
      rd(OFF_OUT, 33'h3);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_VAPP, 32'h7);
      wr(OFF_DAPP, 32'h0);
      wr(OFF_VAPP, 32'h20007);
      wr(OFF_CTRL, 32'h2);
      wt(30);
      rd(OFF_OUT, 33'h7);
      wr(OFF_VAPP, 32'h1);
      rd(OFF_ERR, 33'h0ffffff9c);
      rd(OFF_CTRL, 33'h1);
      want <= 1'b1;
      wt(30);
      rd(OFF_CTRL, 33'h0);
      want <= 1'b0;
      wt(30);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_VAPP, 32'h9);
      wr(OFF_DAPP, 32'h0);
      wr(OFF_VAPP, 32'h30009);
      wr(OFF_CTRL, 32'h2);
      wt(30);
      rd(OFF_CTRL, 33'h1);
      want <= 1'b1;
      wt(30);
      rd(OFF_CTRL, 33'h1);
      want <= 1'b0;
      wt(30);
      rd(OFF_CTRL, 33'h0);
      wr(OFF_WAIT, 32'hfa);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_VAPP, 32'hb);
      wr(OFF_DAPP, 32'h0);
      wr(OFF_VAPP, 32'h2000b);
      wr(OFF_CTRL, 32'h2);
      wt(9000);
      rd(OFF_CTRL, 33'h1);
      wt(1500);
      rd(OFF_CTRL, 33'h0);
      want <= 1'b1;
      wt(30);
      wr(OFF_CTRL, 32'h2);
      wt(10);
      rd(OFF_CTRL, 33'h0);
      wr(OFF_WAMP, 32'h64);
      wr(OFF_WDUR, 32'ha0);
      for (int t = 0; t < 5; t++)
      begin
         wr(OFF_CTRL, 32'h1);
         wr(OFF_WAVE, t);
         wt(100);
         rd(OFF_PNTS, 33'h10);
      end
      wr(OFF_WLIM, 32'h32);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_WAVE, 32'h5);
      wt(10);
      rd(OFF_PNTS, 33'h1);
      wr(OFF_QSTR, 32'h0);
      rd(OFF_QDAT, 33'h32);
      wrap_up();
   end
endmodule
